/* core/mgd_group_decode.sv */
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
// group decoder and executor with apb access to its registers
module mgd_group_decode (
	// clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              nrst_i,
	// apb slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [7:0]        paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic                   pready_o,
	output logic [31:0]            prdata_o,
	output logic                   pslverr_o,
	// panel switches and i/o bus
	input  wire logic [2:0]        panel_switch_i,
	input  wire logic [15:0]       io_in_i,
	input  wire logic              io_sense_i,
	output mgd_pkg::mgd_io_s       io_req_o,
	output logic                   io_strobe_o,
	// memory and remote run requests
	output mgd_pkg::mgd_mem_s      mem_wr_o,
	output logic                   mem_wr_strobe_o,
	output logic [15:0]            remote_run_addr_o,
	output logic                   remote_run_strobe_o
);
	////////////////////////////////////////////////////////////////////////
	// state
	logic [19:0]         sync1_q;
	logic [19:0]         sync2_q;
	mgd_pkg::mgd_state_e state_q;
	logic [3:0]          cnt_q;
	logic [3:0]          lastcyc_q;
	logic [15:0]         ir_q;
	logic [15:0]         word2_q;
	logic [15:0]         mdata_q;
	logic [15:0]         a_q;
	logic [15:0]         b_q;
	logic [15:0]         x_q;
	logic [15:0]         p_q;
	logic                ovf_q;
	logic                taken_q;
	logic                pready_q;
	logic [31:0]         prdata_q;
	logic                pslverr_q;
	mgd_pkg::mgd_io_s    io_req_q;
	logic                io_strobe_q;
	mgd_pkg::mgd_mem_s   mem_q;
	logic                mem_strobe_q;
	logic [15:0]         rr_addr_q;
	logic                rr_strobe_q;

	// all selected condition bits must hold; empty field always holds
	function automatic logic cond_ok(input logic [8:0] f,
			input logic [8:0] c);
		cond_ok = &(c | ~f);
	endfunction

	function automatic logic [3:0] cycles_of(input logic [15:0] w,
			input logic take, input logic dz);
		logic [3:0] n;
		logic [5:0] sub;
		logic [2:0] m;
		sub = w[8:3];
		m   = w[mgd_pkg::M_LSB +: 3];
		n   = mgd_pkg::CYC_ONE;
		if (w[mgd_pkg::OP_LSB +: 4] == mgd_pkg::OP_IO) begin
			if (m == mgd_pkg::IO_SEN)
				n = mgd_pkg::CYC_TWO;
			else if (m != mgd_pkg::IO_EXC)
				n = (w[8:6] == 3'h0) ? mgd_pkg::CYC_THREE
					: mgd_pkg::CYC_TWO;
		end else if (w[mgd_pkg::OP_LSB +: 4] == mgd_pkg::OP_NONADDR) begin
			case (m)
			mgd_pkg::M_JMP,
			mgd_pkg::M_XEC: n = mgd_pkg::CYC_TWO;
			mgd_pkg::M_BRANCH_LINK_ALWAYS: n = take ? mgd_pkg::CYC_THREE
				: mgd_pkg::CYC_TWO;
			mgd_pkg::M_IMM: begin
				if (sub == mgd_pkg::SUB_MUL)
					n = mgd_pkg::CYC_MUL;
				else if (sub == mgd_pkg::SUB_DIV)
					n = dz ? mgd_pkg::CYC_DIV_MIN : mgd_pkg::CYC_DIV_MAX;
				else if (sub == mgd_pkg::SUB_INR)
					n = mgd_pkg::CYC_THREE;
				else
					n = mgd_pkg::CYC_TWO;
				// extended forms fetch one more word
				if (w[2])
					n = n + 4'h1;
			end
			default: n = mgd_pkg::CYC_ONE;
			endcase
		end
		cycles_of = n;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pins pass two flops before use
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_q <= 20'h00000;
			sync2_q <= 20'h00000;
		end else begin
			sync1_q <= {panel_switch_i, io_sense_i, io_in_i};
			sync2_q <= sync1_q;
		end
	end

	logic [2:0]  sw_w;
	logic        sense_w;
	logic [15:0] io_in_w;
	logic [8:0]  cond_w;
	assign sw_w    = sync2_q[19:17];
	assign sense_w = sync2_q[16];
	assign io_in_w = sync2_q[15:0];
	assign cond_w  = {sw_w, x_q == 16'h0000, b_q == 16'h0000,
		a_q == 16'h0000, a_q[15], ~a_q[15], ovf_q};

	////////////////////////////////////////////////////////////////////////
	// apb decode; apb writes reach registers only while no instruction runs
	logic hit_ins_w, hit_w2_w, hit_md_w, hit_a_w, hit_b_w, hit_x_w;
	logic hit_p_w, hit_st_w, hit_any_w, acc_w, wr_w, running_w;
	logic [31:0] rdata_w;
	assign hit_ins_w = paddr_i == mgd_pkg::ADDR_INSTR;
	assign hit_w2_w  = paddr_i == mgd_pkg::ADDR_WORD2;
	assign hit_md_w  = paddr_i == mgd_pkg::ADDR_MDATA;
	assign hit_a_w   = paddr_i == mgd_pkg::ADDR_A;
	assign hit_b_w   = paddr_i == mgd_pkg::ADDR_B;
	assign hit_x_w   = paddr_i == mgd_pkg::ADDR_X;
	assign hit_p_w   = paddr_i == mgd_pkg::ADDR_P;
	assign hit_st_w  = paddr_i == mgd_pkg::ADDR_STATUS;
	assign hit_any_w = hit_ins_w | hit_w2_w | hit_md_w | hit_a_w
		| hit_b_w | hit_x_w | hit_p_w | hit_st_w;
	assign running_w = state_q == mgd_pkg::ST_RUN;
	assign acc_w     = psel_i & penable_i & pready_q;
	assign wr_w      = acc_w & pwrite_i & ~running_w & hit_any_w;
	assign rdata_w   = hit_ins_w ? {16'h0000, ir_q}
		: hit_w2_w ? {16'h0000, word2_q}
		: hit_md_w ? {16'h0000, mdata_q}
		: hit_a_w  ? {16'h0000, a_q}
		: hit_b_w  ? {16'h0000, b_q}
		: hit_x_w  ? {16'h0000, x_q}
		: hit_p_w  ? {16'h0000, p_q}
		: hit_st_w ? {20'h00000, lastcyc_q, 5'h00, taken_q, ovf_q,
			running_w}
		: 32'h00000000;

	// one wait state keeps prdata and pready straight from flops
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= psel_i & penable_i & ~pready_q;
			prdata_q  <= rdata_w;
			pslverr_q <= psel_i & penable_i & ~pready_q & ~hit_any_w;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// launch of a new instruction
	logic [15:0] lw_w;
	logic        launch_w, l_take_w, l_dz_w;
	logic [3:0]  l_cyc_w;
	logic [15:0] l_iodat_w;
	assign lw_w     = pwdata_i[15:0];
	assign launch_w = wr_w & hit_ins_w;
	assign l_take_w = cond_ok(lw_w[8:0], cond_w);
	assign l_dz_w   = (lw_w[2] ? mdata_q : word2_q) == 16'h0000;
	assign l_cyc_w  = cycles_of(lw_w, l_take_w, l_dz_w);
	assign l_iodat_w = (lw_w[7:6] == 2'h0) ? mdata_q
		: {16{lw_w[6]}} & a_q | {16{lw_w[7]}} & b_q;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= mgd_pkg::ST_IDLE;
			cnt_q   <= 4'h0;
		end else begin
			unique case (state_q)
			mgd_pkg::ST_IDLE: if (launch_w) begin
				state_q <= mgd_pkg::ST_RUN;
				cnt_q   <= l_cyc_w - 4'h1;
			end
			mgd_pkg::ST_RUN: if (cnt_q == 4'h0)
				state_q <= mgd_pkg::ST_IDLE;
			else
				cnt_q <= cnt_q - 4'h1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// execution at the last cycle of an instruction
	logic        commit_w, is_io_w, is_na_w, rc_go_w;
	logic [2:0]  mf_w;
	logic [5:0]  sub_w;
	logic [15:0] opnd_w, maddr_w, src_or_w, rc_val_w, sum_w, dif_w, dsr_w;
	logic [31:0] prod_w, quo_w, rem_w;
	assign commit_w = running_w & (cnt_q == 4'h0);
	assign mf_w     = ir_q[mgd_pkg::M_LSB +: 3];
	assign sub_w    = ir_q[8:3];
	assign is_io_w  = ir_q[mgd_pkg::OP_LSB +: 4] == mgd_pkg::OP_IO;
	assign is_na_w  = ir_q[mgd_pkg::OP_LSB +: 4] == mgd_pkg::OP_NONADDR;
	assign opnd_w   = ir_q[2] ? mdata_q : word2_q;
	assign maddr_w  = ir_q[2] ? word2_q : p_q + 16'h0001;
	assign src_or_w = {16{ir_q[5]}} & x_q | {16{ir_q[4]}} & b_q
		| {16{ir_q[3]}} & a_q;
	assign rc_val_w = (ir_q[7:6] == 2'h1) ? src_or_w + 16'h0001
		: (ir_q[7:6] == 2'h2) ? ~src_or_w
		: (ir_q[7:6] == 2'h3) ? src_or_w - 16'h0001
		: src_or_w;
	assign rc_go_w  = ~ir_q[8] | ovf_q;
	assign sum_w    = a_q + opnd_w;
	assign dif_w    = a_q - opnd_w;
	assign prod_w   = {16'h0000, b_q} * {16'h0000, opnd_w};
	// divisor forced nonzero; a zero divisor only sets overflow
	assign dsr_w    = (opnd_w == 16'h0000) ? 16'h0001 : opnd_w;
	assign quo_w    = {a_q, b_q} / {16'h0000, dsr_w};
	assign rem_w    = {a_q, b_q} % {16'h0000, dsr_w};

	logic [15:0]       a_d, b_d, x_d, p_d;
	logic              ovf_d, mem_we_d, rr_d;
	mgd_pkg::mgd_mem_s mem_d;
	always_comb begin
		a_d        = a_q;
		b_d        = b_q;
		x_d        = x_q;
		p_d        = p_q + 16'h0002;
		ovf_d      = ovf_q;
		mem_d.addr = maddr_w;
		mem_d.data = opnd_w + 16'h0001;
		mem_we_d   = 1'b0;
		rr_d       = 1'b0;
		if (is_io_w) begin
			case (mf_w)
			mgd_pkg::IO_SEN: p_d = sense_w ? word2_q : p_q + 16'h0002;
			mgd_pkg::IO_IN: if (ir_q[8:6] == 3'h0) begin
				mem_we_d   = 1'b1;
				mem_d.addr = word2_q;
				mem_d.data = io_in_w;
			end else begin
				p_d = p_q + 16'h0001;
				if (ir_q[6])
					a_d = (ir_q[8] ? 16'h0000 : a_q) | io_in_w;
				if (ir_q[7])
					b_d = (ir_q[8] ? 16'h0000 : b_q) | io_in_w;
			end
			mgd_pkg::IO_OUT: if (ir_q[8:6] != 3'h0)
				p_d = p_q + 16'h0001;
			default: p_d = p_q + 16'h0001;
			endcase
		end else if (is_na_w) begin
			case (mf_w)
			mgd_pkg::M_RC: begin
				p_d = p_q + 16'h0001;
				if (rc_go_w) begin
					if (ir_q[0])
						a_d = rc_val_w;
					if (ir_q[1])
						b_d = rc_val_w;
					if (ir_q[2])
						x_d = rc_val_w;
				end
			end
			mgd_pkg::M_JMP: if (taken_q)
				p_d = word2_q;
			mgd_pkg::M_BRANCH_LINK_ALWAYS: if (taken_q) begin
				mem_we_d   = 1'b1;
				mem_d.addr = word2_q;
				mem_d.data = p_q + 16'h0002;
				p_d        = word2_q + 16'h0001;
			end
			mgd_pkg::M_XEC: rr_d = taken_q;
			mgd_pkg::M_IMM: begin
				case (sub_w)
				mgd_pkg::SUB_LDA: a_d = opnd_w;
				mgd_pkg::SUB_LDB: b_d = opnd_w;
				mgd_pkg::SUB_LDX: x_d = opnd_w;
				mgd_pkg::SUB_INR: mem_we_d = 1'b1;
				mgd_pkg::SUB_STA: begin
					mem_we_d   = 1'b1;
					mem_d.data = a_q;
				end
				mgd_pkg::SUB_STB: begin
					mem_we_d   = 1'b1;
					mem_d.data = b_q;
				end
				mgd_pkg::SUB_STX: begin
					mem_we_d   = 1'b1;
					mem_d.data = x_q;
				end
				mgd_pkg::SUB_ORA: a_d = a_q | opnd_w;
				mgd_pkg::SUB_ERA: a_d = a_q ^ opnd_w;
				mgd_pkg::SUB_ANA: a_d = a_q & opnd_w;
				mgd_pkg::SUB_ADD: begin
					a_d   = sum_w;
					ovf_d = ovf_q | (a_q[15] == opnd_w[15])
						& (sum_w[15] != a_q[15]);
				end
				mgd_pkg::SUB_SUB: begin
					a_d   = dif_w;
					ovf_d = ovf_q | (a_q[15] != opnd_w[15])
						& (dif_w[15] != a_q[15]);
				end
				mgd_pkg::SUB_MUL: {a_d, b_d} = prod_w;
				mgd_pkg::SUB_DIV: if (opnd_w == 16'h0000
						|| quo_w[31:16] != 16'h0000)
					ovf_d = 1'b1;
				else begin
					a_d = rem_w[15:0];
					b_d = quo_w[15:0];
				end
				default: ;
				endcase
			end
			default: p_d = p_q + 16'h0001;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// architectural registers
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			{ir_q, word2_q, mdata_q} <= {3{mgd_pkg::RST_WORD}};
			{a_q, b_q, x_q, p_q}     <= {4{mgd_pkg::RST_WORD}};
			ovf_q     <= 1'b0;
			taken_q   <= 1'b0;
			lastcyc_q <= 4'h0;
		end else if (wr_w) begin
			if (hit_ins_w) begin
				ir_q      <= lw_w;
				taken_q   <= l_take_w;
				lastcyc_q <= l_cyc_w;
			end
			if (hit_w2_w) word2_q <= lw_w;
			if (hit_md_w) mdata_q <= lw_w;
			if (hit_a_w) a_q <= lw_w;
			if (hit_b_w) b_q <= lw_w;
			if (hit_x_w) x_q <= lw_w;
			if (hit_p_w) p_q <= lw_w;
			if (hit_st_w) ovf_q <= pwdata_i[mgd_pkg::STAT_OVF];
		end else if (commit_w) begin
			{a_q, b_q, x_q, p_q} <= {a_d, b_d, x_d, p_d};
			ovf_q <= ovf_d;
		end
	end

	// bus request stands from launch until the next launch
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			io_req_q     <= '0;
			io_strobe_q  <= 1'b0;
			mem_q        <= '0;
			mem_strobe_q <= 1'b0;
			rr_addr_q    <= mgd_pkg::RST_WORD;
			rr_strobe_q  <= 1'b0;
		end else begin
			io_strobe_q  <= launch_w
				& (lw_w[mgd_pkg::OP_LSB +: 4] == mgd_pkg::OP_IO);
			if (launch_w)
				io_req_q <= '{fn: lw_w[10:9], dev: lw_w[8:0],
					data: l_iodat_w};
			mem_strobe_q <= commit_w & mem_we_d;
			if (commit_w & mem_we_d)
				mem_q <= mem_d;
			rr_strobe_q  <= commit_w & rr_d;
			if (commit_w & rr_d)
				rr_addr_q <= word2_q;
		end
	end

	assign pready_o            = pready_q;
	assign prdata_o            = prdata_q;
	assign pslverr_o           = pslverr_q;
	assign io_req_o            = io_req_q;
	assign io_strobe_o         = io_strobe_q;
	assign mem_wr_o            = mem_q;
	assign mem_wr_strobe_o     = mem_strobe_q;
	assign remote_run_addr_o   = rr_addr_q;
	assign remote_run_strobe_o = rr_strobe_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	logic rc_cmt_w, l_na_w;
	assign rc_cmt_w = commit_w & is_na_w & (mf_w == mgd_pkg::M_RC) & rc_go_w;
	assign l_na_w   = launch_w
		& (lw_w[mgd_pkg::OP_LSB +: 4] == mgd_pkg::OP_NONADDR);

	sequence s_busy1;
		running_w ##1 !running_w;
	endsequence
	sequence s_busy2;
		running_w [*2] ##1 !running_w;
	endsequence
	sequence s_busy3;
		running_w [*3] ##1 !running_w;
	endsequence

	property p_rc_copy;
		rc_cmt_w && ir_q[7:6] == 2'h0 && ir_q[0] |=> a_q == $past(src_or_w);
	endproperty
	a_rc_copy: assert property (p_rc_copy) else $error("copy wrong");
	property p_rc_zero;
		rc_cmt_w && ir_q[7:3] == 5'h00 && ir_q[1] |=> b_q == 16'h0000;
	endproperty
	a_rc_zero: assert property (p_rc_zero) else $error("zero wrong");
	property p_rc_or;
		rc_cmt_w && ir_q[7:3] == 5'h07 && ir_q[2]
			|=> x_q == ($past(a_q) | $past(b_q) | $past(x_q));
	endproperty
	a_rc_or: assert property (p_rc_or) else $error("or wrong");
	property p_rc_comp;
		rc_cmt_w && ir_q[7:6] == 2'h2 && ir_q[0] |=> a_q == ~$past(src_or_w);
	endproperty
	a_rc_comp: assert property (p_rc_comp) else $error("cpl wrong");
	property p_rc_hold;
		commit_w && is_na_w && mf_w == mgd_pkg::M_RC && ir_q[8] && !ovf_q
			|=> $stable(a_q) && $stable(b_q) && $stable(x_q);
	endproperty
	a_rc_hold: assert property (p_rc_hold) else $error("cond rc");
	property p_jmp_time;
		l_na_w && lw_w[11:9] == mgd_pkg::M_JMP |=> s_busy2;
	endproperty
	a_jmp_time: assert property (p_jmp_time) else $error("jmp time");
	property p_jmp_dest;
		commit_w && is_na_w && mf_w == mgd_pkg::M_JMP && taken_q
			|=> p_q == $past(word2_q);
	endproperty
	a_jmp_dest: assert property (p_jmp_dest) else $error("jmp dest");
	property p_mark_full;
		l_na_w && lw_w[11:0] == 12'h400 |=> s_busy3;
	endproperty
	a_mark_full: assert property (p_mark_full) else $error("mark 3");
	property p_mark_miss;
		l_na_w && lw_w[11:9] == mgd_pkg::M_BRANCH_LINK_ALWAYS && !l_take_w |=> s_busy2;
	endproperty
	a_mark_miss: assert property (p_mark_miss) else $error("mark 2");
	property p_mark_store;
		commit_w && is_na_w && mf_w == mgd_pkg::M_BRANCH_LINK_ALWAYS && taken_q
			|=> mem_wr_strobe_o && mem_wr_o.addr == $past(word2_q)
			&& p_q == $past(word2_q) + 16'h0001;
	endproperty
	a_mark_store: assert property (p_mark_store) else $error("mark");
	property p_exc_time;
		launch_w && lw_w[15:9] == 7'h40 |=> s_busy1;
	endproperty
	a_exc_time: assert property (p_exc_time) else $error("exc time");
	property p_out_ab;
		launch_w && lw_w[15:9] == 7'h43 && lw_w[8:6] == 3'h3
			|=> io_strobe_o && io_req_o.data == ($past(a_q) | $past(b_q));
	endproperty
	a_out_ab: assert property (p_out_ab) else $error("out a|b");
	property p_mul_time;
		l_na_w && lw_w[11:9] == mgd_pkg::M_IMM && lw_w[8:2] == 7'h1c
			|=> cnt_q + 4'h1 == mgd_pkg::CYC_MUL;
	endproperty
	a_mul_time: assert property (p_mul_time) else $error("mul time");
endmodule

/* core/mgd_pkg.sv */
// shared constants and carrier types for the group decoder
// Notes on behaviour
// - bits 5-3 pick sources, 2-0 destinations
// - no source selected loads zero, one cycle
// - several sources are ORed together
// - bits 7-6 pick unchanged, increment, complement, decrement
// - bit 8 set: act only if overflow
// - conditional increment/decrement add/subtract overflow, one cycle
// - condition bits map flags, registers and switches
// - jump when all selected conditions hold, two cycles
// - unconditional jump-and-mark takes three cycles
// - conditional jump-and-mark: two missed, three taken
// - execute group: same condition, two cycles
// - immediate loads of A, B, X take two
// - immediate bump three, multiply ten, divide ten-fourteen
// - i/o functions: control, sense, input, output
// - input ORs bus into A/B, optionally cleared first
// - output drives A, B or A|B; memory three
// - extended forms take three, multiply eleven, divide 11-15
// - extended bump and replace takes four cycles
package mgd_pkg;
	// apb byte addresses
	localparam logic [7:0] ADDR_INSTR  = 8'h00;
	localparam logic [7:0] ADDR_WORD2  = 8'h04;
	localparam logic [7:0] ADDR_MDATA  = 8'h08;
	localparam logic [7:0] ADDR_A      = 8'h0c;
	localparam logic [7:0] ADDR_B      = 8'h10;
	localparam logic [7:0] ADDR_X      = 8'h14;
	localparam logic [7:0] ADDR_P      = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1c;
	localparam int         STAT_OVF    = 1;
	localparam logic [15:0] RST_WORD   = 16'h0000;
	// instruction word layout
	localparam int         OP_LSB      = 12;
	localparam int         M_LSB       = 9;
	localparam logic [3:0] OP_NONADDR  = 4'h0;
	localparam logic [3:0] OP_IO       = 4'h8;
	localparam logic [2:0] M_JMP       = 3'h1;
	localparam logic [2:0] M_BRANCH_LINK_ALWAYS      = 3'h2;
	localparam logic [2:0] M_XEC       = 3'h3;
	localparam logic [2:0] M_RC        = 3'h5;
	localparam logic [2:0] M_IMM       = 3'h6;
	localparam logic [2:0] IO_EXC      = 3'h0;
	localparam logic [2:0] IO_SEN      = 3'h1;
	localparam logic [2:0] IO_IN       = 3'h2;
	localparam logic [2:0] IO_OUT      = 3'h3;
	// six-bit sub codes of the immediate and extended group
	localparam logic [5:0] SUB_LDA     = 6'h01;
	localparam logic [5:0] SUB_LDB     = 6'h02;
	localparam logic [5:0] SUB_LDX     = 6'h03;
	localparam logic [5:0] SUB_INR     = 6'h04;
	localparam logic [5:0] SUB_STA     = 6'h05;
	localparam logic [5:0] SUB_STB     = 6'h06;
	localparam logic [5:0] SUB_STX     = 6'h07;
	localparam logic [5:0] SUB_ORA     = 6'h09;
	localparam logic [5:0] SUB_ADD     = 6'h0a;
	localparam logic [5:0] SUB_ERA     = 6'h0b;
	localparam logic [5:0] SUB_SUB     = 6'h0c;
	localparam logic [5:0] SUB_ANA     = 6'h0d;
	localparam logic [5:0] SUB_MUL     = 6'h0e;
	localparam logic [5:0] SUB_DIV     = 6'h0f;
	// cycle counts
	localparam logic [3:0] CYC_ONE     = 4'h1;
	localparam logic [3:0] CYC_TWO     = 4'h2;
	localparam logic [3:0] CYC_THREE   = 4'h3;
	localparam logic [3:0] CYC_MUL     = 4'ha;
	localparam logic [3:0] CYC_DIV_MIN = 4'ha;
	localparam logic [3:0] CYC_DIV_MAX = 4'he;
	typedef enum logic [0:0] {ST_IDLE, ST_RUN} mgd_state_e;
	typedef struct packed {
		logic [1:0]  fn;
		logic [8:0]  dev;
		logic [15:0] data;
	} mgd_io_s;
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
	} mgd_mem_s;
endpackage

/* tb/mgd_group_decode_tb.sv */
// self-checking bench of the group decoder, driven over apb
`timescale 1ns/1ps
module mgd_group_decode_tb;
	logic              clk = 1'b0;
	logic              nrst = 1'b0;
	logic              psel = 1'b0;
	logic              pen = 1'b0;
	logic              pwr = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0;
	logic [2:0]        sw = 3'h0;
	logic [15:0]       io_in = 16'h0000;
	logic              sense = 1'b0;
	logic              prdy, perr, pe, io_stb, mem_stb, rr_stb;
	logic [31:0]       prdata, r, st;
	logic [15:0]       rr_addr, p0;
	mgd_pkg::mgd_io_s  io_req;
	mgd_pkg::mgd_mem_s mem;
	int                err_count = 0;
	int                n_compared = 0;
	int                cyc = 0;
	int                n_mem = 0;
	int                n_rr = 0;
	int                n_io = 0;
	int                n;
	////////////////////////////////////////////////////////////////////
	mgd_group_decode i_mgd_group_decode (
		.core_clk_i(clk), .nrst_i(nrst),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .pready_o(prdy),
		.prdata_o(prdata), .pslverr_o(perr),
		.panel_switch_i(sw), .io_in_i(io_in), .io_sense_i(sense),
		.io_req_o(io_req), .io_strobe_o(io_stb),
		.mem_wr_o(mem), .mem_wr_strobe_o(mem_stb),
		.remote_run_addr_o(rr_addr), .remote_run_strobe_o(rr_stb)
	);
	always #4 clk = ~clk;
	// strobes last one cycle, so they are counted here, not polled
	always @(posedge clk) begin
		cyc++;
		n_mem += int'(mem_stb === 1'b1);
		n_rr += int'(rr_stb === 1'b1);
		n_io += int'(io_stb === 1'b1);
		if (cyc == 20000) begin
			err_count++;
			end_sim;
		end
	end
	////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, a);
		n_compared++;
		if (a !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, a);
		end
	endtask
	// one idle cycle between transfers keeps psel from double writes
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [15:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		r = prdata;
		pe = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rchk(input string nm, input logic [7:0] a,
			input logic [15:0] e);
		apb(1'b0, a, 16'h0000);
		chk(nm, e, r[15:0]);
	endtask
	task automatic run(input logic [15:0] iw, w2);
		wr(mgd_pkg::ADDR_WORD2, w2);
		wr(mgd_pkg::ADDR_INSTR, iw);
		do apb(1'b0, mgd_pkg::ADDR_STATUS, 16'h0000);
		while (r[0] !== 1'b0);
		st = r;
	endtask
	task automatic cyc_is(input logic [3:0] e);
		chk("cycles", {12'h000, e}, {12'h000, st[11:8]});
	endtask
	function automatic logic [15:0] nw(logic [2:0] m, logic [8:0] a);
		return {mgd_pkg::OP_NONADDR, m, a};
	endfunction
	function automatic logic [15:0] io(logic [2:0] m, logic [8:0] a);
		return {mgd_pkg::OP_IO, m, a};
	endfunction
	////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int i = 0; i < 8; i++) begin
			rchk("reset", 8'(i * 4), mgd_pkg::RST_WORD);
		end
		rchk("unmapped data", 8'h20, 16'h0000);
		chk("unmapped err", 16'h0001, {15'h0000, pe});
		$display("reset test done");
	endtask
	task automatic t_rc;
		wr(mgd_pkg::ADDR_A, 16'h0005);
		wr(mgd_pkg::ADDR_B, 16'h0003);
		run(nw(mgd_pkg::M_RC, 9'h01c), 16'h0000);
		rchk("or to x", mgd_pkg::ADDR_X, 16'h0007);
		cyc_is(mgd_pkg::CYC_ONE);
		run(nw(mgd_pkg::M_RC, 9'h09c), 16'h0000);
		rchk("inv or", mgd_pkg::ADDR_X, 16'hfff8);
		run(nw(mgd_pkg::M_RC, 9'h03c), 16'h0000);
		rchk("or three", mgd_pkg::ADDR_X, 16'hffff);
		run(nw(mgd_pkg::M_RC, 9'h149), 16'h0000);
		rchk("cond off", mgd_pkg::ADDR_A, 16'h0005);
		wr(mgd_pkg::ADDR_STATUS, 16'h0002);
		run(nw(mgd_pkg::M_RC, 9'h149), 16'h0000);
		rchk("add ovf", mgd_pkg::ADDR_A, 16'h0006);
		run(nw(mgd_pkg::M_RC, 9'h1e4), 16'h0000);
		rchk("sub ovf", mgd_pkg::ADDR_X, 16'hfffe);
		cyc_is(mgd_pkg::CYC_ONE);
		run(nw(mgd_pkg::M_RC, 9'h003), 16'h0000);
		rchk("zero a", mgd_pkg::ADDR_A, 16'h0000);
		rchk("zero b", mgd_pkg::ADDR_B, 16'h0000);
		cyc_is(mgd_pkg::CYC_ONE);
		run(nw(mgd_pkg::M_RC, 9'h049), 16'h0000);
		rchk("inc a", mgd_pkg::ADDR_A, 16'h0001);
		run(nw(mgd_pkg::M_RC, 9'h0c9), 16'h0000);
		rchk("dec a", mgd_pkg::ADDR_A, 16'h0000);
		run(nw(mgd_pkg::M_RC, 9'h089), 16'h0000);
		rchk("inv a", mgd_pkg::ADDR_A, 16'hffff);
		$display("register change test done");
	endtask
	// overflow, a, b, x zero and all switches on: only a < 0 is false
	task automatic t_jmp;
		wr(mgd_pkg::ADDR_A, 16'h0000);
		wr(mgd_pkg::ADDR_B, 16'h0000);
		wr(mgd_pkg::ADDR_X, 16'h0000);
		sw <= 3'h7;
		for (int i = 0; i < 10; i++) begin
			apb(1'b0, mgd_pkg::ADDR_P, 16'h0000);
			p0 = r[15:0];
			run(nw(mgd_pkg::M_JMP, (i < 9) ? 9'(1 << i) : 9'h006),
				16'h0100 + 16'(i));
			chk("jump taken", (i == 2 || i == 9) ? 16'h0000 :
				16'h0001, {15'h0000, st[2]});
			rchk("jump p", mgd_pkg::ADDR_P, (i == 2 || i == 9) ?
				p0 + 16'h0002 : 16'h0100 + 16'(i));
			cyc_is(mgd_pkg::CYC_TWO);
		end
		$display("jump test done");
	endtask
	task automatic t_mark;
		apb(1'b0, mgd_pkg::ADDR_P, 16'h0000);
		p0 = r[15:0];
		n = n_mem;
		run(nw(mgd_pkg::M_BRANCH_LINK_ALWAYS, 9'h000), 16'h0200);
		chk("mark writes", 16'h0001, 16'(n_mem - n));
		chk("mark addr", 16'h0200, mem.addr);
		chk("mark data", p0 + 16'h0002, mem.data);
		rchk("mark p", mgd_pkg::ADDR_P, 16'h0201);
		cyc_is(mgd_pkg::CYC_THREE);
		run(nw(mgd_pkg::M_BRANCH_LINK_ALWAYS, 9'h004), 16'h0220);
		cyc_is(mgd_pkg::CYC_TWO);
		run(nw(mgd_pkg::M_BRANCH_LINK_ALWAYS, 9'h008), 16'h0240);
		cyc_is(mgd_pkg::CYC_THREE);
		n = n_rr;
		// the run target stands for a one-word instruction
		run(nw(mgd_pkg::M_XEC, 9'h001), 16'h0300);
		chk("run addr", 16'h0300, rr_addr);
		cyc_is(mgd_pkg::CYC_TWO);
		run(nw(mgd_pkg::M_XEC, 9'h004), 16'h0310);
		chk("run pulses", 16'h0001, 16'(n_rr - n));
		$display("mark and execute test done");
	endtask
	task automatic t_imm;
		run(nw(mgd_pkg::M_IMM, 9'h008), 16'h1234);
		rchk("lit a", mgd_pkg::ADDR_A, 16'h1234);
		cyc_is(mgd_pkg::CYC_TWO);
		run(nw(mgd_pkg::M_IMM, 9'h020), 16'h0400);
		cyc_is(mgd_pkg::CYC_THREE);
		wr(mgd_pkg::ADDR_B, 16'h0003);
		run(nw(mgd_pkg::M_IMM, 9'h070), 16'h0005);
		rchk("mul lo", mgd_pkg::ADDR_B, 16'h000f);
		cyc_is(mgd_pkg::CYC_MUL);
		run(nw(mgd_pkg::M_IMM, 9'h078), 16'h0002);
		rchk("quot", mgd_pkg::ADDR_B, 16'h0007);
		rchk("rem", mgd_pkg::ADDR_A, 16'h0001);
		cyc_is(mgd_pkg::CYC_DIV_MAX);
		wr(mgd_pkg::ADDR_MDATA, 16'h5a5a);
		run(nw(mgd_pkg::M_IMM, 9'h00c), 16'h0400);
		rchk("far a", mgd_pkg::ADDR_A, 16'h5a5a);
		cyc_is(mgd_pkg::CYC_THREE);
		run(nw(mgd_pkg::M_IMM, 9'h024), 16'h0400);
		cyc_is(4'h4);
		$display("immediate test done");
	endtask
	task automatic t_io;
		wr(mgd_pkg::ADDR_A, 16'h1234);
		wr(mgd_pkg::ADDR_B, 16'h00f0);
		n = n_io;
		run(io(mgd_pkg::IO_OUT, 9'h0ca), 16'h0000);
		chk("out data", 16'h12f4, io_req.data);
		chk("out dev", 16'h00ca, {7'h00, io_req.dev});
		chk("out fn", 16'h0003, {14'h0000, io_req.fn});
		chk("io pulses", 16'h0001, 16'(n_io - n));
		cyc_is(mgd_pkg::CYC_TWO);
		run(io(mgd_pkg::IO_OUT, 9'h00a), 16'h0500);
		cyc_is(mgd_pkg::CYC_THREE);
		io_in <= 16'h0f0f;
		run(io(mgd_pkg::IO_IN, 9'h14a), 16'h0000);
		rchk("clear in", mgd_pkg::ADDR_A, 16'h0f0f);
		cyc_is(mgd_pkg::CYC_TWO);
		io_in <= 16'hf000;
		run(io(mgd_pkg::IO_IN, 9'h04a), 16'h0000);
		rchk("or in", mgd_pkg::ADDR_A, 16'hff0f);
		run(io(mgd_pkg::IO_EXC, 9'h00a), 16'h0000);
		cyc_is(mgd_pkg::CYC_ONE);
		sense <= 1'b1;
		run(io(mgd_pkg::IO_SEN, 9'h00a), 16'h0600);
		rchk("sense hit", mgd_pkg::ADDR_P, 16'h0600);
		cyc_is(mgd_pkg::CYC_TWO);
		sense <= 1'b0;
		run(io(mgd_pkg::IO_SEN, 9'h00a), 16'h0600);
		rchk("sense miss", mgd_pkg::ADDR_P, 16'h0602);
		$display("io test done");
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_reset;
		t_rc;
		t_jmp;
		t_mark;
		t_imm;
		t_io;
		end_sim;
	end
endmodule
